// File: rtl/pss_port_stats.sv
// per-port statistics counters and slave address routing
// Functional notes
// - count retry on nak or missing ack
// - count every byte transmitted
// - count every byte received
// - count each internally generated packet
// - count each transmission acknowledged
// - count priority reads and writes separately
// - count non-priority writes routed locally
// - record bytes sent between checksum and ack
// - last route in eight slots, empties marked
// - report messages queued for sending
// - report buffers currently in use
// - slave role only in host/gate/ascii modes
// - slave address selects entry, routes request
// - empty entry drops request, counted as unrouted, lights faults
// - 128 entries of up to eight drops
// - error increase lights both faults one second
// - table window starts at 0 to 129
`timescale 1ns/100ps
`default_nettype none
module pss_port_stats import pss_pkg::*; #(
  parameter int FAULT_CYCLES = FAULT_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [1:0] mode,
  input wire logic zero_stats,
  input wire logic tx_byte,
  input wire logic rx_byte,
  input wire logic tx_nak,
  input wire logic tx_ack_timeout,
  input wire logic pkt_gen,
  input wire logic tx_acked,
  input wire logic prio_rd,
  input wire logic prio_wr,
  input wire logic np_rd,
  input wire logic np_wr,
  input wire logic rx_err,
  input wire logic chk_sent,
  input wire logic ack_rcvd,
  input wire logic route_valid,
  input wire logic [RW-1:0] route_in,
  input wire logic [LW-1:0] route_len,
  input wire logic queue_push,
  input wire logic queue_pop,
  input wire logic buf_alloc,
  input wire logic buf_free,
  input wire logic [DW-1:0] start_addr,
  input wire logic tbl_we,
  input wire logic [TBL_AW-1:0] tbl_addr,
  input wire logic [RW-1:0] tbl_route,
  input wire logic [LW-1:0] tbl_len,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [DW-1:0] req_addr,
  input wire logic [PW-1:0] req_payload,
  output logic out_valid,
  input wire logic out_ready,
  output logic [RW-1:0] out_route,
  output logic [LW-1:0] out_len,
  output logic [PW-1:0] out_payload,
  output logic [CW-1:0] cnt_retry,
  output logic [CW-1:0] cnt_tx_char,
  output logic [CW-1:0] cnt_rx_char,
  output logic [CW-1:0] cnt_gen,
  output logic [CW-1:0] cnt_acked,
  output logic [CW-1:0] cnt_prio_rd,
  output logic [CW-1:0] cnt_prio_wr,
  output logic [CW-1:0] cnt_np_rd,
  output logic [CW-1:0] cnt_np_wr,
  output logic [CW-1:0] cnt_rx_err,
  output logic [CW-1:0] cnt_unroute,
  output logic [CW-1:0] delay_count,
  output logic [DW-1:0] pad_suggest,
  output logic [RW-1:0] last_route,
  output logic [CW-1:0] queue_count,
  output logic [CW-1:0] bufs_in_use,
  output logic fault_red,
  output logic fault_green
);
  localparam int BW = RW + LW + PW;
  localparam logic [31:0] FAULT_LOAD = 32'(FAULT_CYCLES);

  logic [CW-1:0] cnt_q [NCNT];
  logic [NCNT-1:0] ev;
  logic slave_en;
  logic [DW-1:0] idx;
  logic in_win;
  logic [LW-1:0] ent_len;
  logic [RW-1:0] ent_route;
  logic ent_ok;
  logic take;
  logic bin_valid;
  logic bin_ready;
  logic unroute_ev;
  logic [RW-1:0] tbl_route_q [TBL_N];
  logic [LW-1:0] tbl_len_q [TBL_N];
  logic [BW-1:0] bout;
  pss_dly_t dly_q;
  logic [CW-1:0] dly_run_q;
  logic [CW-1:0] dly_cnt_q;
  logic [RW-1:0] route_q;
  logic [CW-1:0] queue_q;
  logic [CW-1:0] bufs_q;
  logic [31:0] fault_q;

  // slave role gated by port mode
  assign slave_en = (mode != PSS_MODE_OTHER);
  assign idx = req_addr - start_addr;
  assign in_win = (req_addr >= start_addr) && (idx < 8'h80);
  assign ent_route = tbl_route_q[idx[TBL_AW-1:0]];
  assign ent_len = tbl_len_q[idx[TBL_AW-1:0]];
  assign ent_ok = slave_en && in_win && (ent_len != 4'h0);
  // a request waits only when it would be routed; drops never stall
  assign req_ready = ent_ok ? bin_ready : 1'b1;
  assign take = ce && req_valid && req_ready;
  assign bin_valid = ce && req_valid && ent_ok;
  assign unroute_ev = take && slave_en && !ent_ok;

  // routing table, 128 entries of up to eight drops
  always_ff @(posedge clock) begin
    if (ce && tbl_we) begin
      tbl_route_q[tbl_addr] <= tbl_route;
      tbl_len_q[tbl_addr] <= tbl_len;
    end
  end

  pss_buf2 #(.W(BW)) u_buf (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .in_valid(bin_valid),
    .in_ready(bin_ready),
    .in_data({ent_route, ent_len, req_payload}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(bout)
  );
  assign out_route = bout[BW-1 -: RW];
  assign out_len = bout[PW +: LW];
  assign out_payload = bout[PW-1:0];

  assign ev[C_RETRY] = tx_nak || tx_ack_timeout;
  assign ev[C_TXCH] = tx_byte;
  assign ev[C_RXCH] = rx_byte;
  assign ev[C_GEN] = pkt_gen;
  assign ev[C_ACKD] = tx_acked;
  assign ev[C_PRD] = prio_rd;
  assign ev[C_PWR] = prio_wr;
  assign ev[C_NPRD] = np_rd;
  assign ev[C_NPWR] = np_wr;
  assign ev[C_RXERR] = rx_err;
  assign ev[C_UNRT] = unroute_ev;

  // an event in the clearing cycle still counts once
  for (genvar i = 0; i < NCNT; i++) begin : g_cnt
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        cnt_q[i] <= CNT_RST;
      end else if (ce) begin
        if (zero_stats) begin
          cnt_q[i] <= ev[i] ? 16'h0001 : CNT_RST;
        end else if (ev[i]) begin
          cnt_q[i] <= cnt_q[i] + 16'h0001;
        end
      end
    end
  end

  assign cnt_retry = cnt_q[C_RETRY];
  assign cnt_tx_char = cnt_q[C_TXCH];
  assign cnt_rx_char = cnt_q[C_RXCH];
  assign cnt_gen = cnt_q[C_GEN];
  assign cnt_acked = cnt_q[C_ACKD];
  assign cnt_prio_rd = cnt_q[C_PRD];
  assign cnt_prio_wr = cnt_q[C_PWR];
  assign cnt_np_rd = cnt_q[C_NPRD];
  assign cnt_np_wr = cnt_q[C_NPWR];
  assign cnt_rx_err = cnt_q[C_RXERR];
  assign cnt_unroute = cnt_q[C_UNRT];

  // delay bytes: counted from checksum until the ack
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dly_q <= PSS_DLY_IDLE;
      dly_run_q <= CNT_RST;
      dly_cnt_q <= CNT_RST;
    end else if (ce) begin
      unique case (dly_q)
        PSS_DLY_IDLE: begin
          if (chk_sent) begin
            dly_q <= PSS_DLY_WAIT;
            dly_run_q <= CNT_RST;
          end
        end
        PSS_DLY_WAIT: begin
          if (ack_rcvd) begin
            dly_q <= PSS_DLY_IDLE;
            dly_cnt_q <= dly_run_q + (tx_byte ? 16'h0001 : CNT_RST);
          end else if (tx_byte) begin
            dly_run_q <= dly_run_q + 16'h0001;
          end
        end
      endcase
      if (zero_stats) begin
        dly_cnt_q <= CNT_RST;
      end
    end
  end
  assign delay_count = dly_cnt_q;
  // the tuning tool writes this into pad control; saturation is its concern
  assign pad_suggest = dly_cnt_q[DW-1:0] + PAD_MARGIN;

  // whole route taken in one edge, never a mix of two messages
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      route_q <= '0;
    end else if (ce && route_valid) begin
      for (int s = 0; s < NDROP; s++) begin
        route_q[s*DW +: DW] <= (LW'(s) < route_len) ? route_in[s*DW +: DW] : DROP_EMPTY;
      end
    end
  end
  assign last_route = route_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      queue_q <= CNT_RST;
    end else if (ce) begin
      if (queue_push && !queue_pop) begin
        queue_q <= queue_q + 16'h0001;
      end else if (queue_pop && !queue_push && queue_q != CNT_RST) begin
        queue_q <= queue_q - 16'h0001;
      end
    end
  end
  assign queue_count = queue_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bufs_q <= CNT_RST;
    end else if (ce) begin
      if (buf_alloc && !buf_free) begin
        bufs_q <= bufs_q + 16'h0001;
      end else if (buf_free && !buf_alloc && bufs_q != CNT_RST) begin
        bufs_q <= bufs_q - 16'h0001;
      end
    end
  end
  assign bufs_in_use = bufs_q;

  // any error counter step restarts the one-second hold
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fault_q <= 32'h0;
    end else if (ce) begin
      if ((ev & ERR_MASK) != '0) begin
        fault_q <= FAULT_LOAD;
      end else if (fault_q != 32'h0) begin
        fault_q <= fault_q - 32'h1;
      end
    end
  end
  assign fault_red = (fault_q != 32'h0);
  assign fault_green = (fault_q != 32'h0);

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_retry_counts: assert property (ce && !zero_stats && (tx_nak || tx_ack_timeout)
    |=> cnt_retry == $past(cnt_retry) + 16'h0001)
    else $error("retry counter missed an event");
  a_txchar_counts: assert property (ce && !zero_stats && tx_byte |=> cnt_tx_char == $past(cnt_tx_char) + 16'h0001)
    else $error("tx byte not counted");
  a_rxchar_steady: assert property (ce && !zero_stats && !rx_byte |=> $stable(cnt_rx_char))
    else $error("rx counter moved without a byte");
  a_zero_clears: assert property (ce && zero_stats && !tx_acked |=> cnt_acked == 16'h0000)
    else $error("zero request did not clear");
  a_empty_drops: assert property (ce && req_valid && slave_en && !ent_ok && !out_valid |=> !out_valid)
    else $error("empty entry was forwarded");
  a_route_forward: assert property (take && ent_ok ##1 ce |-> out_valid)
    else $error("routed request not buffered");
  a_mode_gate: assert property (ce && mode == PSS_MODE_OTHER && !out_valid |=> !out_valid)
    else $error("slave path active in wrong mode");
  a_fault_hold: assert property (ce && ((ev & ERR_MASK) != '0) |=> fault_red && fault_green [*2])
    else $error("fault lights not lit after error");
  a_route_empty: assert property (ce && route_valid && route_len == 4'h0 |=> last_route[DW-1:0] == DROP_EMPTY)
    else $error("empty route not marked");
  a_delay_capture: assert property (ce && dly_q == PSS_DLY_WAIT && ack_rcvd && !tx_byte && !zero_stats
    |=> delay_count == $past(dly_run_q))
    else $error("delay count not captured");

  // counters and table checked against the events that feed them
  a_gen_counts: assert property (ce && !zero_stats && pkt_gen
    |=> cnt_gen == $past(cnt_gen) + 16'h0001)
    else $error("generated packet not counted");
  a_acked_counts: assert property (ce && !zero_stats && tx_acked
    |=> cnt_acked == $past(cnt_acked) + 16'h0001)
    else $error("acknowledged send not counted");
  a_prio_split: assert property (ce && !zero_stats && prio_rd && !prio_wr
    |=> $stable(cnt_prio_wr))
    else $error("priority read moved write counter");
  a_npwr_counts: assert property (ce && !zero_stats && np_wr
    |=> cnt_np_wr == $past(cnt_np_wr) + 16'h0001)
    else $error("non-priority write not counted");
  a_delay_idle: assert property (ce && !zero_stats && dly_q == PSS_DLY_IDLE
    |=> $stable(delay_count))
    else $error("delay count moved while idle");
  a_route_whole: assert property (ce && route_valid && route_len >= 4'h8
    |=> last_route == $past(route_in))
    else $error("full route not taken whole");
  a_queue_steady: assert property (ce && queue_push && queue_pop
    |=> $stable(queue_count))
    else $error("queue moved on push with pop");
  a_bufs_floor: assert property (ce && buf_free && !buf_alloc && bufs_in_use == 16'h0000
    |=> bufs_in_use == 16'h0000)
    else $error("buffer count went below zero");
  a_unroute_counts: assert property (ce && !zero_stats && take && slave_en && !ent_ok
    |=> cnt_unroute == $past(cnt_unroute) + 16'h0001)
    else $error("dropped request not counted");
  a_table_write: assert property (ce && tbl_we
    |=> tbl_len_q[$past(tbl_addr)] == $past(tbl_len) && tbl_route_q[$past(tbl_addr)] == $past(tbl_route))
    else $error("table entry not written");
  a_win_limit: assert property (ce && req_valid && req_addr < start_addr && !out_valid
    |=> !out_valid)
    else $error("request below window was routed");
  a_ce_freeze: assert property (!ce
    |=> $stable(cnt_tx_char) && $stable(last_route) && $stable(out_valid))
    else $error("state moved while clock enable low");

  c_routed: cover property (take && ent_ok);
  c_dropped: cover property (unroute_ev);
  c_stall: cover property (req_valid && !req_ready);
  c_delay: cover property (dly_q == PSS_DLY_WAIT ##1 dly_q == PSS_DLY_IDLE);
  c_freeze: cover property (!ce ##1 ce);
endmodule
`default_nettype wire

// File: rtl/pss_pkg.sv
// package: constants for port statistics and slave routing
package pss_pkg;
  localparam int CW = 16;
  localparam int DW = 8;
  localparam int NDROP = 8;
  localparam int RW = DW * NDROP;
  localparam int LW = 4;
  localparam int TBL_N = 128;
  localparam int TBL_AW = 7;
  localparam int PW = 8;
  localparam logic [DW-1:0] START_MAX = 8'h81;
  localparam logic [DW-1:0] DROP_EMPTY = 8'hff;
  localparam logic [DW-1:0] PAD_MARGIN = 8'h0a;
  localparam logic [CW-1:0] CNT_RST = 16'h0000;
  localparam int CLK_MHZ = 200;
  localparam int FAULT_MS = 1000;
  localparam int FAULT_CYC = FAULT_MS * 1000 * CLK_MHZ;
  localparam int NCNT = 11;
  localparam int C_RETRY = 0;
  localparam int C_TXCH = 1;
  localparam int C_RXCH = 2;
  localparam int C_GEN = 3;
  localparam int C_ACKD = 4;
  localparam int C_PRD = 5;
  localparam int C_PWR = 6;
  localparam int C_NPRD = 7;
  localparam int C_NPWR = 8;
  localparam int C_RXERR = 9;
  localparam int C_UNRT = 10;
  localparam logic [NCNT-1:0] ERR_MASK = 11'h601;
  typedef enum logic [1:0] {
    PSS_MODE_OTHER = 2'h0,
    PSS_MODE_HOST = 2'h1,
    PSS_MODE_GATE = 2'h2,
    PSS_MODE_ASCII = 2'h3
  } pss_mode_t;
  typedef enum logic {
    PSS_DLY_IDLE = 1'b0,
    PSS_DLY_WAIT = 1'b1
  } pss_dly_t;
endpackage

// File: rtl/pss_buf2.sv
// two-entry valid/ready buffer
`timescale 1ns/100ps
`default_nettype none
module pss_buf2 import pss_pkg::*; #(
  parameter int W = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_q [2];
  logic wp_q;
  logic rp_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;
  assign out_data = mem_q[rp_q];

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 2'h1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end

  a_buf_no_overflow: assert property (@(posedge clock) disable iff (rst) cnt_q <= 2'h2)
    else $error("buffer count above two");
endmodule
`default_nettype wire

// File: sim/pss_sink.sv
// partner model: downstream consumer of routed slave messages
`timescale 1ns/100ps
`default_nettype none
module pss_sink import pss_pkg::*; (
  input wire logic clock,
  input wire logic rst,
  input wire logic stall,
  input wire logic out_valid,
  output var logic out_ready,
  input wire logic [RW-1:0] out_route,
  input wire logic [LW-1:0] out_len,
  input wire logic [PW-1:0] out_payload
);
  logic [LW+RW+PW-1:0] q[$];
  // ready is registered, so a stall shows one edge late, as a slow receiver would
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= !stall;
      if (out_valid && out_ready) begin
        q.push_back({out_len, out_route, out_payload});
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/tb.sv
// testbench for port statistics and slave routing
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pss_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [19:0] ev = '0;
  logic [1:0] mode = 2'h0;
  logic [RW-1:0] rin = '0;
  logic [RW-1:0] trt = '0;
  logic [LW-1:0] rlen = '0;
  logic [LW-1:0] tlen = '0;
  logic [DW-1:0] start = '0;
  logic [DW-1:0] ra = '0;
  logic [TBL_AW-1:0] tad = '0;
  logic [PW-1:0] rp = '0;
  logic rv = 1'b0;
  logic stall = 1'b0;
  logic ce = 1'b1;
  wire logic rr, ov, ordy, fr, fg;
  wire logic [RW-1:0] orte, lroute;
  wire logic [LW-1:0] olen;
  wire logic [PW-1:0] opl, pad;
  wire logic [CW-1:0] cn [11];
  wire logic [CW-1:0] dly, qc, bc;
  int errors = 0;
  int check_count = 0;
  localparam logic [RW-1:0] RT = 64'hffffffffff050265;
  always #2.5 clock = ~clock;
  pss_port_stats #(.FAULT_CYCLES(20)) dut (.clock(clock), .rst(rst), .ce(ce), .mode(mode), .zero_stats(ev[18]),
    .tx_byte(ev[0]), .rx_byte(ev[1]), .tx_nak(ev[2]), .tx_ack_timeout(ev[3]), .pkt_gen(ev[4]), .tx_acked(ev[5]),
    .prio_rd(ev[6]), .prio_wr(ev[7]), .np_rd(ev[8]), .np_wr(ev[9]), .rx_err(ev[10]), .chk_sent(ev[11]),
    .ack_rcvd(ev[12]), .route_valid(ev[13]), .route_in(rin), .route_len(rlen), .queue_push(ev[14]),
    .queue_pop(ev[15]), .buf_alloc(ev[16]), .buf_free(ev[17]), .start_addr(start), .tbl_we(ev[19]),
    .tbl_addr(tad), .tbl_route(trt), .tbl_len(tlen), .req_valid(rv), .req_ready(rr), .req_addr(ra),
    .req_payload(rp), .out_valid(ov), .out_ready(ordy), .out_route(orte), .out_len(olen), .out_payload(opl),
    .cnt_retry(cn[0]), .cnt_tx_char(cn[1]), .cnt_rx_char(cn[2]), .cnt_gen(cn[3]), .cnt_acked(cn[4]),
    .cnt_prio_rd(cn[5]), .cnt_prio_wr(cn[6]), .cnt_np_rd(cn[7]), .cnt_np_wr(cn[8]), .cnt_rx_err(cn[9]),
    .cnt_unroute(cn[10]), .delay_count(dly), .pad_suggest(pad), .last_route(lroute), .queue_count(qc),
    .bufs_in_use(bc), .fault_red(fr), .fault_green(fg));
  pss_sink sink (.clock(clock), .rst(rst), .stall(stall), .out_valid(ov), .out_ready(ordy), .out_route(orte),
    .out_len(olen), .out_payload(opl));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // one-cycle event pulse; returns where its effect is visible
  task automatic pl(input logic [19:0] m);
    ev <= m;
    @(posedge clock);
    ev <= '0;
    @(posedge clock);
  endtask
  // request held until taken; last lowers valid and lets an edge pass
  task automatic send(input logic [7:0] a, input logic [7:0] p, input bit last);
    int n;
    ra <= a;
    rp <= p;
    rv <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (rr !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      report_and_stop();
    end
    if (last) begin
      rv <= 1'b0;
      @(posedge clock);
    end
  endtask
  task automatic t_counters();
    for (int i = 0; i < 11; i++) pl(20'h1 << i);
    pl(20'h0000c);
    for (int i = 0; i < 11; i++) chk("counter", (i == 0) ? 3 : (i == 10) ? 0 : 1, cn[i]);
    pl(20'h40001);
    chk("zero with event", 1, cn[1]);
    chk("zeroed", 0, cn[0]);
  endtask
  task automatic t_delay();
    pl(20'h00800);
    repeat (3) pl(20'h00001);
    pl(20'h01000);
    chk("delay", 3, dly);
    chk("pad", 8'h0d, pad);
    ce <= 1'b0;
    pl(20'h00001);
    chk("frozen", 4, cn[1]);
    ce <= 1'b1;
    pl(20'h00001);
    chk("resumed", 5, cn[1]);
  endtask
  task automatic t_route();
    rin <= 64'h1122334455660e65;
    rlen <= 4'h2;
    pl(20'h02000);
    chk("route", 64'hffffffffffff0e65, lroute);
    rlen <= 4'h0;
    pl(20'h02000);
    chk("no route", 64'hffffffffffffffff, lroute);
    rlen <= 4'h8;
    pl(20'h02000);
    chk("full route", 64'h1122334455660e65, lroute);
  endtask
  task automatic t_queue();
    repeat (2) pl(20'h04000);
    repeat (3) pl(20'h08000);
    pl(20'h04000);
    pl(20'h0c000);
    chk("queue", 1, qc);
    repeat (3) pl(20'h10000);
    pl(20'h20000);
    chk("buffers", 2, bc);
    repeat (3) pl(20'h20000);
    chk("buffers floor", 0, bc);
  endtask
  task automatic t_slave();
    int n;
    mode <= 2'h1;
    start <= START_MAX;
    tad <= 7'h03;
    trt <= RT;
    tlen <= 4'h3;
    pl(20'h80000);
    tad <= 7'h04;
    tlen <= 4'h0;
    pl(20'h80000);
    stall <= 1'b1;
    send(8'h84, 8'ha1, 0);
    send(8'h84, 8'ha2, 0);
    rp <= 8'ha3;
    repeat (2) @(posedge clock);
    chk("ready full", 0, rr);
    stall <= 1'b0;
    send(8'h84, 8'ha3, 1);
    n = 0;
    while (sink.q.size() < 3 && n < 50) begin
      @(posedge clock);
      n++;
    end
    chk("routed count", 3, sink.q.size());
    for (int i = 0; i < 3; i++) chk("payload", 8'ha1 + i, sink.q[i][7:0]);
    chk("out route", RT, sink.q[0][71:8]);
    chk("out len", 3, sink.q[0][75:72]);
    mode <= 2'h2;
    send(8'h84, 8'hc0, 1);
    mode <= 2'h3;
    send(8'h84, 8'hc1, 1);
    repeat (3) @(posedge clock);
    chk("gate ascii routed", 5, sink.q.size());
    chk("ascii payload", 8'hc1, sink.q[4][7:0]);
    send(8'h80, 8'hb0, 1);
    send(8'h85, 8'hb1, 1);
    mode <= 2'h0;
    send(8'h84, 8'hb2, 1);
    repeat (4) @(posedge clock);
    chk("dropped", 2, cn[10]);
    chk("nothing routed", 5, sink.q.size());
  endtask
  task automatic t_fault();
    repeat (30) @(posedge clock);
    chk("fault idle", 2'b00, {fr, fg});
    pl(20'h00400);
    @(posedge clock);
    chk("fault lit", 2'b11, {fr, fg});
    repeat (25) @(posedge clock);
    chk("fault out", 2'b00, {fr, fg});
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("ready idle", 1, rr);
    t_counters();
    t_delay();
    t_route();
    t_queue();
    t_slave();
    t_fault();
    report_and_stop();
  end
endmodule
`default_nettype wire
